/* dv/accumulator_stack_arith_unit_tb.sv */
// self-checking bench for the stack arith unit
// assumes the register map of arith_regs.svh and a 25 MHz pclk
`include "arith_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module accumulator_stack_arith_unit_tb;
    // clock, reset and bus nets
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    // bookkeeping
    int          bad_count = 0;
    int          compares  = 0;
    int          cycles    = 0;
    logic [31:0] q;
    logic        e;

    accumulator_stack_arith_unit #(.DEPTH(8)) accumulator_stack_arith_unit_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq));

    seq_model seq_model_i (
        .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    // 40 ns clock
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // hang guard: whole run needs a few hundred cycles
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 4000) begin
            bad_count++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop

    // compare seen against expected, four-state
    task automatic chk(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic rd(input logic [11:0] a);
        seq_model_i.xfer(1'b0, a, 32'h0000_0000, q, e);
    endtask : rd

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        seq_model_i.xfer(1'b1, a, d, q, e);
    endtask : wr

    // load two words, run one op, read back acc, level one and flags;
    // flags are read before the next op may overwrite them
    task automatic run_op(input logic [31:0] lo, input logic [31:0] hi,
                          input logic [2:0] op, input logic [31:0] acc_x,
                          input logic [31:0] stk_x, input logic [31:0] fl_x,
                          input logic [31:0] care = 32'h0000_01ff,
                          input logic [31:0] acare = 32'hffff_ffff);
        wr(`ACC_OFS, lo);
        wr(`ACC_OFS, hi);
        rd(`STK1_OFS);
        chk("level one after load", q, lo);
        wr(`CMD_OFS, {29'h0, op});
        rd(`ACC_OFS);
        chk("accumulator", q & acare, acc_x);
        rd(`STK1_OFS);
        chk("level one after op", q, stk_x);
        rd(`FLAGS_OFS);
        chk("flags", q & care, fl_x);
    endtask : run_op

    // reset values and an unmapped address
    task automatic t_reset();
        rd(`ACC_OFS);
        chk("acc at reset", q, 32'h0000_0000);
        rd(`FLAGS_OFS);
        chk("flags at reset", q, 32'h0000_0000);
        rd(`MASK_OFS);
        chk("mask at reset", q, 32'h0000_0000);
        chk("mapped read error", {31'h0, e}, 32'h0000_0000);
        rd(12'h018);
        chk("unmapped read error", {31'h0, e}, 32'h0000_0001);
    endtask : t_reset

    // low-half decimal carry only
    task automatic t_add16();
        run_op(32'h1, 32'h9999, `OP_ADD,
               32'h1_0000, 32'h0, 32'h002);
    endtask : t_add16

    // full-word carry to zero; level two moves up
    task automatic t_add32();
        run_op(32'h1, 32'h9999_9999, `OP_ADD,
               32'h0, 32'h1_0000, 32'h007);
    endtask : t_add32

    // negative difference; carry flags must survive
    task automatic t_sub();
        run_op(32'h7, 32'h5, `OP_SUB,
               32'h9999_9998, 32'h0, 32'h03e);
    endtask : t_sub

    // upper digits of the accumulator are ignored
    task automatic t_mul();
        run_op(32'h10, 32'h5555_1234, `OP_MUL,
               32'h1_2340, 32'h9999_9998, 32'h01e);
    endtask : t_mul

    // quotient to acc, remainder into level one, no pop
    task automatic t_div();
        run_op(32'h7, 32'h100, `OP_DIV,
               32'h14, 32'h2, 32'h01e);
    endtask : t_div

    // zero divisor raises the range event through the mask
    task automatic t_range_irq();
        wr(`MASK_OFS, 32'h1 << `I_RANGE);
        rd(`MASK_OFS);
        chk("mask readback", q, 32'h4);
        chk("done is masked", {31'h0, irq}, 32'h0);
        rd(`STS_OFS);
        chk("status before", q, 32'h1 << `I_DONE);
        run_op(32'h0, 32'h25, `OP_DIV,
               32'h25, 32'h0, 32'h11e);
        chk("irq raised", {31'h0, irq}, 32'h1);
        rd(`STS_OFS);
        chk("status range", q, 32'h5);
        chk("irq cleared", {31'h0, irq}, 32'h0);
    endtask : t_range_irq

    // signed overflow; borrow and range flags stay
    task automatic t_binovf();
        run_op(32'h1, 32'h7fff_ffff, `OP_ADDB,
               32'h8000_0000, 32'h25, 32'h17a);
    endtask : t_binovf

    // binary wrap to zero with both carries
    task automatic t_binzero();
        run_op(32'h1, 32'hffff_ffff, `OP_ADDB,
               32'h0, 32'h8000_0000, 32'h11f);
    endtask : t_binzero

    // non-decimal digit; result itself is meaningless
    task automatic t_badbcd();
        run_op(32'h1, 32'ha, `OP_ADD, 32'h0, 32'h0,
               32'h180, 32'h1c0, 32'h0);
    endtask : t_badbcd

    // reset, then every scenario in order; flags chain between them
    initial begin
        presetn = 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_add16();
        t_add32();
        t_sub();
        t_mul();
        t_div();
        t_range_irq();
        t_binovf();
        t_binzero();
        t_badbcd();
        report_and_stop();
    end
endmodule : accumulator_stack_arith_unit_tb
`default_nettype wire

/* dv/seq_model.sv */
// sequencer model: issues apb transfers to the stack arith unit
// assumes pclk from the bench; xfer is entered just after a rising edge
`timescale 1ns/10ps
`default_nettype none

module seq_model (
    // clock
    input  wire logic        pclk,
    // apb request
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    // apb answer
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    // bus idle until the first transfer
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0000_0000;
    end

    // one transfer; waits for pready, never assumes a latency
    task automatic xfer(input logic wr, input logic [11:0] a,
                        input logic [31:0] d, output logic [31:0] q,
                        output logic e);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no latency assumed; the bench's cycle ceiling ends a dead wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // released data shows a changed pattern, not the stale word
        pwdata  <= ~d;
        // idle edge: the next setup never shares this time step
        @(posedge pclk);
    endtask : xfer
endmodule : seq_model
`default_nettype wire

/* logic/accumulator_stack_arith_unit.sv */
// accumulator plus stack arithmetic unit behind an apb slave
// assumes apb master on pclk; ops are issued by writing the command reg
`include "arith_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module accumulator_stack_arith_unit #(
    parameter int DEPTH = 8   // stack levels, level one is index 0
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // interrupt
    output logic             irq
);

    // shifting needs at least two levels
    if (DEPTH < 2) begin : g_chk
        $error("DEPTH must be at least 2");
    end

    // whole module state
    typedef struct packed {
        arith_pkg::fsm_type               st;    // op sequencer
        logic [2:0]                       op;    // op being run
        arith_pkg::word_type              acc;   // accumulator
        logic [DEPTH-1:0][31:0]           stk;   // stack, [0] = level one
        logic [8:0]                       flags; // status flags
        logic [3:0]                       sts;   // sticky irq status
        logic [3:0]                       mask;  // irq enables
        logic [3:0]                       cap;   // status bits read out
        arith_pkg::word_type              rdata; // read data
        logic                             rdy;   // apb ready
        logic                             err;   // apb error
        logic                             irq;   // interrupt level
    } state_type;

    state_type r;       // registered state
    state_type next_r;  // next state

    // bcd add with carry in; returns {carry32, carry16, sum}
    function automatic logic [33:0] bcd_add(input logic [31:0] a,
                                            input logic [31:0] b,
                                            input logic        cin);
        logic [4:0]  d;
        logic        c;
        logic        c16;
        logic [31:0] s;
        c   = cin;
        c16 = 1'b0;
        s   = 32'h0;
        for (int i = 0; i < 8; i++) begin
            d = {1'b0, a[4*i+:4]} + {1'b0, b[4*i+:4]} + {4'h0, c};
            c = (d > 5'h09);
            // decimal adjust of a digit past nine
            if (c) begin
                d = d + 5'h06;
            end
            s[4*i+:4] = d[3:0];
            if (i == 3) begin
                c16 = c;
            end
        end
        return {c, c16, s};
    endfunction : bcd_add

    // nines complement, digit by digit
    function automatic logic [31:0] nines(input logic [31:0] b);
        logic [31:0] s;
        s = 32'h0;
        for (int i = 0; i < 8; i++) begin
            s[4*i+:4] = 4'h9 - b[4*i+:4];
        end
        return s;
    endfunction : nines

    // true when every digit is 0 to 9
    function automatic logic bcd_ok(input logic [31:0] a);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < 8; i++) begin
            if (a[4*i+:4] > 4'h9) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction : bcd_ok

    // eight bcd digits to binary
    function automatic logic [26:0] to_bin(input logic [31:0] a);
        logic [26:0] v;
        v = 27'h0;
        for (int i = 7; i >= 0; i--) begin
            v = 27'(v * 27'h00a + {23'h0, a[4*i+:4]});
        end
        return v;
    endfunction : to_bin

    // binary below 10^8 to eight bcd digits
    function automatic logic [31:0] to_bcd(input logic [26:0] v);
        logic [31:0] s;
        logic [26:0] t;
        s = 32'h0;
        t = v;
        for (int i = 0; i < 8; i++) begin
            s[4*i+:4] = 4'(t % 27'h00a);
            t = t / 27'h00a;
        end
        return s;
    endfunction : to_bcd

    // apb phase decode
    logic done_xfer;  // access phase completing at this edge
    logic load_acc;   // accumulator load taking effect
    logic div_zero;   // divisor digits give zero
    assign done_xfer = psel && penable && r.rdy;
    assign load_acc  = done_xfer && pwrite && (paddr == `ACC_OFS)
                       && (r.st == arith_pkg::st_idle);
    assign div_zero  = (r.stk[0][15:0] == 16'h0000);

    // next state: bus, op execution, interrupt status
    always_comb begin
        logic [33:0] t;     // bcd adder result
        logic [31:0] res;   // accumulator result
        logic [26:0] a;     // binary dividend / factor
        logic [26:0] b;     // binary divisor / factor
        logic [32:0] bs;    // binary sum
        logic [3:0]  ev;    // irq events
        logic [3:0]  clr;   // status bits read out now
        logic        pop;   // drop level one
        t   = 34'h0;
        res = r.acc;
        a   = 27'h0;
        b   = 27'h0;
        bs  = 33'h0;
        ev  = 4'h0;
        clr = 4'h0;
        pop = 1'b0;
        next_r     = r;
        next_r.rdy = 1'b0;
        next_r.err = 1'b0;

        // first access cycle: fetch read data, ready next cycle
        if (psel && penable && !r.rdy) begin
            next_r.rdy   = 1'b1;
            next_r.rdata = 32'h0;
            next_r.cap   = 4'h0;
            if (paddr == `ACC_OFS) begin
                next_r.rdata = r.acc;
            end else if (paddr == `STK1_OFS) begin
                next_r.rdata = r.stk[0];
            end else if (paddr == `CMD_OFS) begin
                next_r.rdata = {23'h0, r.st == arith_pkg::st_exec,
                                5'h0, r.op};
            end else if (paddr == `FLAGS_OFS) begin
                next_r.rdata = {23'h0, r.flags};
            end else if (paddr == `STS_OFS) begin
                next_r.rdata = {28'h0, r.sts};
                // only bits shown to software get cleared later
                next_r.cap   = pwrite ? 4'h0 : r.sts;
            end else if (paddr == `MASK_OFS) begin
                next_r.rdata = {28'h0, r.mask};
            end else begin
                // unmapped offset
                next_r.err = 1'b1;
            end
        end

        // completing edge: writes and read side effects
        if (load_acc) begin
            next_r.acc = pwdata;
            next_r.stk = {r.stk[DEPTH-2:0], r.acc};
        end
        if (done_xfer && pwrite && (paddr == `CMD_OFS)
            && (r.st == arith_pkg::st_idle)) begin
            // unknown codes start nothing
            if (pwdata[2:0] >= `OP_ADD && pwdata[2:0] <= `OP_ADDB) begin
                next_r.op = pwdata[2:0];
                next_r.st = arith_pkg::st_exec;
            end
        end
        if (done_xfer && pwrite && (paddr == `MASK_OFS)) begin
            next_r.mask = pwdata[3:0];
        end
        if (done_xfer && !pwrite && (paddr == `STS_OFS)) begin
            clr = r.cap;
        end

        // one cycle of execution; each op writes only its own flags
        if (r.st == arith_pkg::st_exec) begin
            next_r.st  = arith_pkg::st_idle;
            ev[`I_DONE] = 1'b1;
            case (r.op)
                `OP_ADD: begin
                    t   = bcd_add(r.acc, r.stk[0], 1'b0);
                    res = t[31:0];
                    next_r.flags[`F_C16] = t[32];
                    next_r.flags[`F_C32] = t[33];
                    next_r.flags[`F_NEG] = 1'b0;
                    next_r.flags[`F_BAD] =
                        !(bcd_ok(r.acc) && bcd_ok(r.stk[0]));
                    pop = 1'b1;
                end
                `OP_SUB: begin
                    // ten's complement add; no carry means borrow
                    t   = bcd_add(r.acc, nines(r.stk[0]), 1'b1);
                    res = t[31:0];
                    next_r.flags[`F_B16] = !t[32];
                    next_r.flags[`F_B32] = !t[33];
                    next_r.flags[`F_NEG] = !t[33];
                    next_r.flags[`F_BAD] =
                        !(bcd_ok(r.acc) && bcd_ok(r.stk[0]));
                    pop = 1'b1;
                end
                `OP_MUL: begin
                    a   = to_bin({16'h0, r.acc[15:0]});
                    b   = to_bin({16'h0, r.stk[0][15:0]});
                    res = to_bcd(27'(a * b));
                    next_r.flags[`F_NEG] = 1'b0;
                    next_r.flags[`F_BAD] = !(bcd_ok({16'h0, r.acc[15:0]})
                        && bcd_ok({16'h0, r.stk[0][15:0]}));
                    pop = 1'b1;
                end
                `OP_DIV: begin
                    a = to_bin(r.acc);
                    b = to_bin({16'h0, r.stk[0][15:0]});
                    next_r.flags[`F_RANGE] = div_zero;
                    next_r.flags[`F_NEG]   = 1'b0;
                    next_r.flags[`F_BAD]   = !(bcd_ok(r.acc)
                        && bcd_ok({16'h0, r.stk[0][15:0]}));
                    ev[`I_RANGE] = div_zero;
                    // a zero divisor leaves accumulator and stack alone
                    if (!div_zero) begin
                        res = to_bcd(a / b);
                        next_r.stk[0] = to_bcd(a % b);
                    end
                end
                `OP_ADDB: begin
                    bs  = {1'b0, r.acc} + {1'b0, r.stk[0]};
                    res = bs[31:0];
                    next_r.flags[`F_C16] = ((r.acc[15:0] + r.stk[0][15:0])
                                            < r.acc[15:0]);
                    next_r.flags[`F_C32] = bs[32];
                    next_r.flags[`F_NEG] = bs[31];
                    next_r.flags[`F_OVF] = (r.acc[31] == r.stk[0][31])
                        && (bs[31] != r.acc[31]);
                    ev[`I_OVF] = next_r.flags[`F_OVF];
                    pop = 1'b1;
                end
                default: begin
                    ev = 4'h0;
                end
            endcase
            next_r.acc = res;
            next_r.flags[`F_ZERO] = (res == 32'h0);
            ev[`I_BAD] = next_r.flags[`F_BAD] && (r.op != `OP_ADDB);
            if (pop) begin
                next_r.stk = {32'h0, r.stk[DEPTH-1:1]};
            end
        end

        // new events win over a read clear in the same cycle
        next_r.sts = (r.sts & ~clr) | ev;
        next_r.irq = |(next_r.sts & next_r.mask);
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r       <= '0;
            r.st    <= arith_pkg::st_idle;
        end else begin
            r <= next_r;
        end
    end

    // outputs straight from flops
    assign prdata  = r.rdata;
    assign pready  = r.rdy;
    assign pslverr = r.err;
    assign irq     = r.irq;

    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_exec(logic [2:0] opc);
        r.st == arith_pkg::st_exec && r.op == opc;
    endsequence

    property p_add;
        s_exec(`OP_ADD) |=> r.acc ==
            32'(bcd_add($past(r.acc), $past(r.stk[0]), 1'b0));
    endproperty
    a_add:
    assert property (p_add) else $error("bcd add result wrong");

    property p_pop;
        (r.st == arith_pkg::st_exec && r.op != `OP_DIV)
            |=> r.stk[0] == $past(r.stk[1]) && r.stk[DEPTH-1] == 32'h0;
    endproperty
    a_pop:
    assert property (p_pop) else $error("stack not popped");

    property p_sub;
        s_exec(`OP_SUB) |=> r.acc ==
            32'(bcd_add($past(r.acc), nines($past(r.stk[0])), 1'b1));
    endproperty
    a_sub:
    assert property (p_sub) else $error("bcd subtract result wrong");

    property p_div;
        s_exec(`OP_DIV) ##0 !div_zero |=> r.acc == to_bcd(
            to_bin($past(r.acc)) / to_bin({16'h0, $past(r.stk[0][15:0])}));
    endproperty
    a_div:
    assert property (p_div) else $error("bcd quotient wrong");

    property p_rem;
        s_exec(`OP_DIV) ##0 !div_zero |=> r.stk[1] == $past(r.stk[1])
            && r.stk[0] == to_bcd(to_bin($past(r.acc))
               % to_bin({16'h0, $past(r.stk[0][15:0])}));
    endproperty
    a_rem:
    assert property (p_rem) else $error("remainder not in level one");

    property p_addb;
        s_exec(`OP_ADDB) |=> r.acc == $past(r.acc) + $past(r.stk[0]);
    endproperty
    a_addb:
    assert property (p_addb) else $error("binary sum wrong");

    property p_zero;
        r.st == arith_pkg::st_exec |=> r.flags[`F_ZERO] == (r.acc == 32'h0);
    endproperty
    a_zero:
    assert property (p_zero) else $error("zero flag wrong");

    property p_range;
        s_exec(`OP_DIV) |=> r.flags[`F_RANGE] == $past(div_zero)
            ##1 r.sts[`I_RANGE] || !r.flags[`F_RANGE] || $past(done_xfer);
    endproperty
    a_range:
    assert property (p_range) else $error("range flag wrong");

    property p_hold;
        r.st == arith_pkg::st_idle |=> $stable(r.flags);
    endproperty
    a_hold:
    assert property (p_hold) else $error("flag changed without op");

    property p_keep;
        s_exec(`OP_MUL) |=> $stable(r.flags[`F_B32:`F_C16])
            && $stable(r.flags[`F_RANGE]) && $stable(r.flags[`F_OVF]);
    endproperty
    a_keep:
    assert property (p_keep) else $error("multiply touched other flags");

    property p_push;
        load_acc |=> r.stk[0] == $past(r.acc) && r.acc == $past(pwdata);
    endproperty
    a_push:
    assert property (p_push) else $error("load did not push stack");

endmodule : accumulator_stack_arith_unit

`default_nettype wire

/* logic/arith_pkg.sv */
// types shared by the stack arith unit
// assumes the offsets and codes come from arith_regs.svh
package arith_pkg;
    // sequencer of one operation, one-hot
    typedef enum logic [1:0] {
        st_idle = 2'b01,
        st_exec = 2'b10
    } fsm_type;
    // one accumulator or stack word
    typedef logic [31:0] word_type;
endpackage : arith_pkg

/* logic/arith_regs.svh */
// register offsets, field positions and op codes of the stack arith unit
// assumes a 32-bit apb slave with 12-bit byte addresses
`ifndef ARITH_REGS_SVH
`define ARITH_REGS_SVH
// byte offsets
`define ACC_OFS   12'h000
`define STK1_OFS  12'h004
`define CMD_OFS   12'h008
`define FLAGS_OFS 12'h00c
`define STS_OFS   12'h010
`define MASK_OFS  12'h014
// op codes written to the command register
`define OP_ADD  3'h1
`define OP_SUB  3'h2
`define OP_MUL  3'h3
`define OP_DIV  3'h4
`define OP_ADDB 3'h5
// flag bit positions
`define F_ZERO  0
`define F_C16   1
`define F_C32   2
`define F_B16   3
`define F_B32   4
`define F_NEG   5
`define F_OVF   6
`define F_BAD   7
`define F_RANGE 8
// interrupt status bit positions
`define I_DONE  0
`define I_BAD   1
`define I_RANGE 2
`define I_OVF   3
// busy bit in the command register read value
`define CMD_BUSY 8
`endif
